//--- rtl/codec_regs.svh
// register offsets, field positions, reset values and shift counts
// assumes inclusion by the package and by every design file that decodes
`ifndef CODEC_REGS_SVH
`define CODEC_REGS_SVH

// ----------------------------------------
// register offsets (4-bit address space)
// ----------------------------------------
`define ADDR_GAIN 4'h0
`define ADDR_SIDETONE 4'h1
`define ADDR_QUIET 4'h3
`define ADDR_FORMAT 4'h4

// ----------------------------------------
// reset values: sidetone off, 0 dB, mu-law, strobed 2048 kb/s, powered up
// ----------------------------------------
`define GAIN_RESET 8'h00
`define SIDETONE_RESET 8'h00
`define QUIET_RESET 8'h00
`define FORMAT_RESET 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define GAIN_TX_LSB 0
`define GAIN_RX_LSB 3
`define GAIN_MIC 6
`define GAIN_EAR_LO 7
`define ST_SEL_LSB 0
`define ST_ENABLE 3
`define ST_EAR_HI 7
`define QT_RX 0
`define QT_TX 1
`define QT_PORT_PD 2
`define QT_DRV_PD 3
`define FMT_ALAW 0
`define FMT_SMAG 1
`define FMT_MODE_LSB 2

// ----------------------------------------
// command byte layout, per timing
// ----------------------------------------
`define MSB_CMD_RW 7
`define MSB_CMD_ADDR_LSB 0
`define LSB_CMD_RW 0
`define LSB_CMD_ADDR_LSB 4

// ----------------------------------------
// serial clock counts
// ----------------------------------------
`define CMD_LAST_BIT 5'h07
`define CMD_BITS 5'h08
`define DATA_LAST_BIT 5'h0F
`define XFER_BITS 5'h10

// ----------------------------------------
// pcm code points
// ----------------------------------------
`define SMAG_POS_FS 8'hFF
`define SMAG_NEG_ZERO 8'h00
`define MU_MASK 8'h7F
`define A_MASK 8'h55
`define A_POS_FS 8'hAA
`define MU_QUIET 8'h7F
`define A_QUIET 8'h55

`endif

//--- rtl/codec_pkg.sv
// types shared by the control port and the pcm code mapper
// assumes codec_regs.svh is on the include path
`include "codec_regs.svh"

package codec_pkg;

  // timing picked when chip select falls
  typedef enum logic {
    TIMING_MSB,
    TIMING_LSB
  } timing_t;

  // raw register image
  typedef struct packed {
    logic [7:0] format;
    logic [7:0] quiet;
    logic [7:0] sidetone;
    logic [7:0] gain;
  } reg_image_t;

  // decoded settings handed to the analog and digital port sections
  typedef struct packed {
    logic [2:0] txFilterGain;
    logic [2:0] rxFilterGain;
    logic micGainBoost;
    logic [1:0] earpieceGainStep;
    logic sidetoneOn;
    logic [2:0] sidetoneGainSel;
    logic rxQuiet;
    logic txQuiet;
    logic portPowerDown;
    logic driverPowerDown;
    logic aLaw;
    logic codingSelect;
    logic [2:0] portMode;
  } codec_settings_t;

  // xor mask between sign-magnitude and line code; self-inverse
  function automatic logic [7:0] code_mask(input logic aLaw, input logic signMag);
    if (signMag) begin
      code_mask = 8'h00;
    end else if (aLaw) begin
      code_mask = `A_MASK;
    end else begin
      code_mask = `MU_MASK;
    end
  endfunction

endpackage

//--- rtl/pcm_code_map.sv
// pcm code mapper between sign-magnitude samples and line coding
// assumes codeIn is on clk; law and coding bits are quasi-static
`timescale 1ns/1ps
`include "codec_regs.svh"

module pcm_code_map #(
  parameter bit TO_LINE = 1'b1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic aLaw,
  input wire logic signMag,
  input wire logic quiet,
  input wire logic [7:0] codeIn,
  output logic [7:0] codeOut
);
  import codec_pkg::*;

  logic [7:0] mask;
  logic [7:0] quietCode;

  // quiet is negative zero, in whatever coding the output uses
  assign mask = code_mask(aLaw, signMag);
  assign quietCode = TO_LINE ? (`SMAG_NEG_ZERO ^ mask) : `SMAG_NEG_ZERO;

  // one register stage; the same xor maps both ways
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      codeOut <= `SMAG_NEG_ZERO;
    end else if (ce) begin
      if (quiet) begin
        codeOut <= quietCode;
      end else begin
        codeOut <= codeIn ^ mask;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_quiet_code;
    @(posedge clk) disable iff (!nrst)
      (ce && quiet) |=> codeOut == ((!TO_LINE || $past(signMag)) ? `SMAG_NEG_ZERO
        : $past(aLaw) ? `A_QUIET : `MU_QUIET);
  endproperty
  a_quiet_code: assert property (p_quiet_code) else $error("quiet code wrong");

  property p_alaw_full_scale;
    @(posedge clk) disable iff (!nrst)
      (TO_LINE && ce && !quiet && aLaw && !signMag && codeIn == `SMAG_POS_FS)
        |=> codeOut == `A_POS_FS;
  endproperty
  a_alaw_full_scale: assert property (p_alaw_full_scale) else $error("a-law +fs wrong");

endmodule

//--- rtl/codec_serial_control_port.sv
// codec serial control port: shifter on the host's serial clock,
// settings registers and pcm quiet/code mapping on clk
// assumes sclk, csN and the data lines come straight from the host pins
//
// How it works
// - csN falls with sclk high: lsb-first, line A two-way, line B unused
// - csN falls with sclk low: msb-first, send on line A, receive line B
// - half duplex: input ignored during reads, line A silent during writes
// - first eight clocks carry command/address, next eight carry data
// - csN high releases line A and keeps it released
// - data bit order follows timing; command layout differs per timing
// - sample input on sclk rise, change output on sclk fall
// - reset: sidetone off, 0 dB gains, mu-law, strobed mode, powered up
// - three-bit transmit and receive filter gain fields, 1 dB per step
// - filter gain fields live in the gain register at 00h
// - sidetone gain select and enable live in the register at 01h
// - effective a-law choice is register bit or law pin
// - law bit and coding select live in the register at 04h
// - positive full scale codes per coding
// - positive zero codes per coding
// - negative zero is the quiet code per coding
// - negative full scale codes per coding
// - microphone boost bit at 00h picks the higher transmit gain
// - earpiece step picks 0, -6 or -12 dB on top of receive gain
// - quiet bits replace path samples by negative zero
`timescale 1ns/1ps
`include "codec_regs.svh"

module codec_serial_control_port (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic sclk,
  input wire logic csN,
  input wire logic ioLineAIn,
  output logic ioLineAOut,
  output logic ioLineAOeN,
  input wire logic rxLineB,
  input wire logic lawPin,
  input wire logic [7:0] txSample,
  input wire logic [7:0] rxCode,
  output logic [7:0] txCode,
  output logic [7:0] rxSample,
  output codec_pkg::codec_settings_t settings
);
  import codec_pkg::*;

  // ----------------------------------------
  // command decode helpers
  // ----------------------------------------

  // read flag position depends on the timing
  function automatic logic cmd_is_read(input logic [7:0] cmd, input timing_t t);
    if (t == TIMING_LSB) begin
      cmd_is_read = cmd[`LSB_CMD_RW];
    end else begin
      cmd_is_read = cmd[`MSB_CMD_RW];
    end
  endfunction

  // address nibble position depends on the timing
  function automatic logic [3:0] cmd_addr(input logic [7:0] cmd, input timing_t t);
    if (t == TIMING_LSB) begin
      cmd_addr = cmd[`LSB_CMD_ADDR_LSB +: 4];
    end else begin
      cmd_addr = cmd[`MSB_CMD_ADDR_LSB +: 4];
    end
  endfunction

  // index of the data bit sent for a given count
  function automatic logic [2:0] bit_pos(input logic [4:0] cnt, input timing_t t);
    if (t == TIMING_LSB) begin
      bit_pos = cnt[2:0];
    end else begin
      bit_pos = 3'h7 - cnt[2:0];
    end
  endfunction

  // register read mux; unmapped addresses read zero
  function automatic logic [7:0] read_reg(input logic [3:0] a, input reg_image_t img);
    case (a)
      `ADDR_GAIN: read_reg = img.gain;
      `ADDR_SIDETONE: read_reg = img.sidetone;
      `ADDR_QUIET: read_reg = img.quiet;
      `ADDR_FORMAT: read_reg = img.format;
      default: read_reg = 8'h00;
    endcase
  endfunction

  // ----------------------------------------
  // link side, clocked by sclk
  // ----------------------------------------
  logic linkRstN;
  timing_t timing;
  logic rxBit;
  logic [4:0] bitCnt;
  logic [7:0] shiftIn;
  logic [7:0] next_shift;
  logic [7:0] cmdByte;
  logic [7:0] rdByte;
  logic isRead;
  logic [3:0] cmdAddr;
  logic driveA;
  logic txBit;
  logic wrToggle;
  logic [3:0] wrAddr;
  logic [7:0] wrData;
  reg_image_t mirror1;
  reg_image_t mirror2;
  reg_image_t regs;

  // csN high holds the whole shifter in reset, so a cut frame leaves no trace
  assign linkRstN = nrst & ~csN;

  // timing is the sclk level seen as csN falls
  always_ff @(negedge csN or negedge nrst) begin
    if (!nrst) begin
      timing <= TIMING_MSB;
    end else if (sclk) begin
      timing <= TIMING_LSB;
    end else begin
      timing <= TIMING_MSB;
    end
  end

  // in lsb-first timing line B is not listened to
  assign rxBit = (timing == TIMING_LSB) ? ioLineAIn : rxLineB;

  // shift direction follows the timing
  always_comb begin
    if (timing == TIMING_LSB) begin
      next_shift = {rxBit, shiftIn[7:1]};
    end else begin
      next_shift = {shiftIn[6:0], rxBit};
    end
  end

  // bit counter and input shifter, sampled on sclk rise
  always_ff @(posedge sclk or negedge linkRstN) begin
    if (!linkRstN) begin
      bitCnt <= 5'h00;
      shiftIn <= 8'h00;
    end else if (bitCnt != `XFER_BITS) begin
      bitCnt <= bitCnt + 5'h01;
      shiftIn <= next_shift;
    end
  end

  // command byte latched on its eighth clock, with the read data
  always_ff @(posedge sclk or negedge linkRstN) begin
    if (!linkRstN) begin
      cmdByte <= 8'h00;
      rdByte <= 8'h00;
    end else if (bitCnt == `CMD_LAST_BIT) begin
      cmdByte <= next_shift;
      rdByte <= read_reg(cmd_addr(next_shift, timing), mirror2);
    end
  end

  assign isRead = cmd_is_read(cmdByte, timing);
  assign cmdAddr = cmd_addr(cmdByte, timing);

  // completed write handed over by a toggle; not cleared by csN so the
  // clk side never sees a spurious edge when the frame ends
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      wrToggle <= 1'b0;
      wrAddr <= 4'h0;
      wrData <= 8'h00;
    end else if (bitCnt == `DATA_LAST_BIT && !isRead) begin
      wrAddr <= cmdAddr;
      wrData <= next_shift;
      wrToggle <= ~wrToggle;
    end
  end

  // output bit changes on sclk fall, only in the data byte of a read
  always_ff @(negedge sclk or negedge linkRstN) begin
    if (!linkRstN) begin
      driveA <= 1'b0;
      txBit <= 1'b0;
    end else if (isRead && bitCnt >= `CMD_BITS && bitCnt != `XFER_BITS) begin
      driveA <= 1'b1;
      txBit <= rdByte[bit_pos(bitCnt, timing)];
    end else begin
      driveA <= 1'b0;
    end
  end

  assign ioLineAOut = txBit;
  assign ioLineAOeN = ~driveA;

  // register image into the sclk domain; it only moves after a write, and
  // the eight command clocks flush both stages before the read is taken
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      mirror1 <= '0;
      mirror2 <= '0;
    end else begin
      mirror1 <= regs;
      mirror2 <= mirror1;
    end
  end

  // ----------------------------------------
  // register side, clocked by clk
  // ----------------------------------------
  logic wrSync1;
  logic wrSync2;
  logic wrSync3;
  logic wrStrobe;
  logic lawSync1;
  logic lawSync2;

  // toggle and law pin synchronisers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrSync1 <= 1'b0;
      wrSync2 <= 1'b0;
      wrSync3 <= 1'b0;
      lawSync1 <= 1'b0;
      lawSync2 <= 1'b0;
    end else if (ce) begin
      wrSync1 <= wrToggle;
      wrSync2 <= wrSync1;
      wrSync3 <= wrSync2;
      lawSync1 <= lawPin;
      lawSync2 <= lawSync1;
    end
  end

  // wrAddr and wrData sit still for a whole frame after each toggle
  assign wrStrobe = wrSync2 ^ wrSync3;

  // settings registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regs.gain <= `GAIN_RESET;
      regs.sidetone <= `SIDETONE_RESET;
      regs.quiet <= `QUIET_RESET;
      regs.format <= `FORMAT_RESET;
    end else if (ce && wrStrobe) begin
      case (wrAddr)
        `ADDR_GAIN: regs.gain <= wrData;
        `ADDR_SIDETONE: regs.sidetone <= wrData;
        `ADDR_QUIET: regs.quiet <= wrData;
        `ADDR_FORMAT: regs.format <= wrData;
        default: ;
      endcase
    end
  end

  // decoded settings, registered so the outputs come from flip-flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      settings <= '0;
    end else if (ce) begin
      settings.txFilterGain <= regs.gain[`GAIN_TX_LSB +: 3];
      settings.rxFilterGain <= regs.gain[`GAIN_RX_LSB +: 3];
      settings.micGainBoost <= regs.gain[`GAIN_MIC];
      settings.earpieceGainStep <= {regs.sidetone[`ST_EAR_HI], regs.gain[`GAIN_EAR_LO]};
      settings.sidetoneOn <= regs.sidetone[`ST_ENABLE];
      settings.sidetoneGainSel <= regs.sidetone[`ST_SEL_LSB +: 3];
      settings.rxQuiet <= regs.quiet[`QT_RX];
      settings.txQuiet <= regs.quiet[`QT_TX];
      settings.portPowerDown <= regs.quiet[`QT_PORT_PD];
      settings.driverPowerDown <= regs.quiet[`QT_DRV_PD];
      settings.aLaw <= regs.format[`FMT_ALAW] | lawSync2;
      settings.codingSelect <= regs.format[`FMT_SMAG];
      settings.portMode <= regs.format[`FMT_MODE_LSB +: 3];
    end
  end

  // ----------------------------------------
  // pcm paths: transmit to line code, receive back to sign-magnitude
  // ----------------------------------------
  pcm_code_map #(
    .TO_LINE(1'b1)
  ) u_tx_map (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .aLaw(settings.aLaw),
    .signMag(settings.codingSelect),
    .quiet(settings.txQuiet),
    .codeIn(txSample),
    .codeOut(txCode)
  );

  pcm_code_map #(
    .TO_LINE(1'b0)
  ) u_rx_map (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .aLaw(settings.aLaw),
    .signMag(settings.codingSelect),
    .quiet(settings.rxQuiet),
    .codeIn(rxCode),
    .codeOut(rxSample)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_cmd_silent;
    @(posedge sclk) disable iff (!linkRstN)
      (bitCnt < `CMD_BITS) |-> !driveA;
  endproperty
  a_cmd_silent: assert property (p_cmd_silent) else $error("line A driven in command");

  property p_read_bits;
    @(posedge sclk) disable iff (!linkRstN)
      (isRead && bitCnt >= `CMD_BITS && bitCnt != `XFER_BITS)
        |-> driveA && txBit == rdByte[bit_pos(bitCnt, timing)];
  endproperty
  a_read_bits: assert property (p_read_bits) else $error("read bit wrong");

  property p_write_silent;
    @(posedge sclk) disable iff (!linkRstN)
      (!isRead && bitCnt >= `CMD_BITS) |-> !driveA;
  endproperty
  a_write_silent: assert property (p_write_silent) else $error("driven during write");

  property p_write_toggle;
    @(negedge sclk) disable iff (!linkRstN)
      (bitCnt == `XFER_BITS && $past(bitCnt) == `DATA_LAST_BIT && !isRead)
        |-> wrToggle != $past(wrToggle);
  endproperty
  a_write_toggle: assert property (p_write_toggle) else $error("write not handed over");

  property p_no_early_write;
    @(posedge sclk) disable iff (!linkRstN)
      (bitCnt != `XFER_BITS && bitCnt != 5'h00) |-> $stable(wrToggle);
  endproperty
  a_no_early_write: assert property (p_no_early_write) else $error("early write");

  property p_write_lands;
    @(posedge clk) disable iff (!nrst)
      (ce && wrStrobe && wrAddr == `ADDR_FORMAT) |=> regs.format == $past(wrData);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("format write lost");

  property p_law_or;
    @(posedge clk) disable iff (!nrst)
      ce |=> settings.aLaw == ($past(regs.format[`FMT_ALAW]) | $past(lawSync2));
  endproperty
  a_law_or: assert property (p_law_or) else $error("law select wrong");

  property p_released;
    @(posedge clk) disable iff (!nrst)
      csN |-> ioLineAOeN;
  endproperty
  a_released: assert property (p_released) else $error("line A driven while idle");

endmodule

//--- testbench/host_model.sv
// host model: a microcontroller framing accesses on the serial control port
// assumes the bench resolves line A from both enables and a pull-up
`timescale 1ns/1ps

module host_model (
  output logic sclk,
  output logic csN,
  output logic lineAHost,
  output logic lineAHostEn,
  output logic rxLineB,
  output logic inRead,
  input wire logic lineA
);
  localparam time HALF = 24;

  // idle: deselected, clock standing still
  initial begin
    sclk = 1'b0;
    csN = 1'b1;
    lineAHost = 1'b0;
    lineAHostEn = 1'b0;
    rxLineB = 1'b0;
    inRead = 1'b0;
  end

  // one framed access; nBits below 16 cuts the frame short
  task automatic xfer(input logic lsb, input logic rd, input logic [3:0] addr,
                      input logic [7:0] wdata, input int nBits, output logic [7:0] rdata);
    logic [7:0] cmd;
    logic b;
    cmd = lsb ? {addr, 3'b000, rd} : {rd, 3'b000, addr};
    rdata = 8'h00;
    sclk = lsb; // clock level at select picks the timing, idle low in msb-first
    #HALF;
    inRead = rd;
    csN = 1'b0; // held low for the whole frame
    #HALF;
    for (int i = 0; i < nBits; i++) begin
      if (i < 8) begin
        b = lsb ? cmd[i] : cmd[7-i];
      end else begin
        b = lsb ? wdata[i-8] : wdata[15-i];
      end
      sclk = 1'b0; // host data changes while the clock is low
      if (lsb) begin
        lineAHostEn = !(rd && i >= 8); // line A handed over for read data
        lineAHost = b;
        rxLineB = !rxLineB;
      end else begin
        rxLineB = (rd && i >= 8) ? !rxLineB : b; // junk shifted out during a read
      end
      #HALF;
      sclk = 1'b1;
      if (rd && i >= 8) begin
        rdata = lsb ? {lineA, rdata[7:1]} : {rdata[6:0], lineA}; // sampled on rise
      end
      #HALF;
    end
    sclk = 1'b0;
    #HALF;
    csN = 1'b1; // frame closed only after the last bit
    inRead = 1'b0;
    lineAHostEn = 1'b0;
    rxLineB = !rxLineB;
    #400;
  endtask
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the codec serial control port
// assumes host_model provides the framed accesses on the link side
`timescale 1ns/1ps

module tb_top;
  import codec_pkg::*;
  logic clk, nrst, ce, lawPin;
  logic [7:0] txSample, rxCode, rd;
  logic [7:0] smagT[4] = '{8'hFF, 8'h80, 8'h00, 8'h7F};
  logic [7:0] muT[4] = '{8'h80, 8'hFF, 8'h7F, 8'h00};
  logic [7:0] aT[4] = '{8'hAA, 8'hD5, 8'h55, 8'h2A};
  wire logic sclk, csN, lineAHost, lineAHostEn, rxLineB, inRead, lineA;
  logic ioLineAOut, ioLineAOeN;
  logic [7:0] txCode, rxSample;
  codec_settings_t settings;
  int num_errors = 0;
  int total_checks = 0;
  int badOe = 0;

  // line A: device, host, else pull-up
  assign lineA = !ioLineAOeN ? ioLineAOut : (lineAHostEn ? lineAHost : 1'b1);

  initial clk = 1'b0;
  always #20 clk = ~clk;

  host_model host (.sclk(sclk), .csN(csN), .lineAHost(lineAHost), .lineAHostEn(lineAHostEn),
    .rxLineB(rxLineB), .inRead(inRead), .lineA(lineA));

  codec_serial_control_port uut (.clk(clk), .nrst(nrst), .ce(ce), .sclk(sclk), .csN(csN),
    .ioLineAIn(lineA), .ioLineAOut(ioLineAOut), .ioLineAOeN(ioLineAOeN), .rxLineB(rxLineB),
    .lawPin(lawPin), .txSample(txSample), .rxCode(rxCode), .txCode(txCode),
    .rxSample(rxSample), .settings(settings));

  // device may drive line A only in read data, never against the host
  always @(posedge clk) begin
    if (!ioLineAOeN && (csN || !inRead || lineAHostEn)) badOe++;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic lsb, input logic [3:0] a, input logic [7:0] d);
    host.xfer(lsb, 1'b0, a, d, 16, rd);
  endtask

  task automatic rdchk(input logic lsb, input logic [3:0] a, input logic [7:0] exp);
    host.xfer(lsb, 1'b1, a, 8'h00, 16, rd);
    check($sformatf("reg %h", a), rd, exp);
  endtask

  // drive both pcm paths, then look one clock after they are taken
  task automatic pcm(input logic [7:0] tx, input logic [7:0] rx);
    @(posedge clk);
    #1;
    txSample = tx;
    rxCode = rx;
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // hang guard
  initial begin
    #1000000;
    num_errors++;
    tally_and_finish;
  end

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    lawPin = 1'b0;
    txSample = 8'h00;
    rxCode = 8'h00;
    repeat (2) @(posedge clk);
    #1;
    nrst = 1'b1;
    check("settings", settings, 0);
    check("oeN", ioLineAOeN, 1);
    foreach (muT[i]) rdchk(1'b0, (i == 0) ? 4'h0 : (i == 1) ? 4'h1 : 4'h3 + i - 2, 8'h00);
    $display("test reset done");
    // cross-timing write and read back, both bit orders
    wr(1'b0, 4'h0, 8'hF5);
    rdchk(1'b1, 4'h0, 8'hF5);
    wr(1'b1, 4'h1, 8'h8E);
    rdchk(1'b0, 4'h1, 8'h8E);
    check("txgain", settings.txFilterGain, 5);
    check("rxgain", settings.rxFilterGain, 6);
    check("mic", settings.micGainBoost, 1);
    check("stsel", settings.sidetoneGainSel, 6);
    check("ston", settings.sidetoneOn, 1);
    check("ear", settings.earpieceGainStep, 3);
    $display("test registers done");
    // unmapped place, then writes cut short
    wr(1'b0, 4'h2, 8'hFF);
    rdchk(1'b0, 4'h2, 8'h00);
    rdchk(1'b1, 4'hF, 8'h00);
    host.xfer(1'b0, 1'b0, 4'h0, 8'h12, 12, rd);
    host.xfer(1'b1, 1'b0, 4'h0, 8'h12, 15, rd);
    rdchk(1'b0, 4'h0, 8'hF5);
    $display("test refusals done");
    // code table for every law and coding
    for (int m = 0; m < 3; m++) begin
      wr(m[0], 4'h4, (m == 0) ? 8'h00 : (m == 1) ? 8'h01 : 8'h02);
      check("alaw", settings.aLaw, m == 1);
      check("smag", settings.codingSelect, m == 2);
      for (int k = 0; k < 4; k++) begin
        pcm(smagT[k], (m == 0) ? muT[k] : (m == 1) ? aT[k] : smagT[k]);
        check("txCode", txCode, (m == 0) ? muT[k] : (m == 1) ? aT[k] : smagT[k]);
        check("rxSample", rxSample, smagT[k]);
      end
    end
    $display("test coding done");
    // law pin ored with the register bit
    wr(1'b0, 4'h4, 8'h00);
    lawPin = 1'b1;
    pcm(8'hFF, 8'hAA);
    pcm(8'hFF, 8'hAA);
    check("txCode law pin", txCode, 8'hAA);
    check("rxSample law pin", rxSample, 8'hFF);
    // quiet bits force negative zero, then release
    wr(1'b1, 4'h3, 8'h03);
    pcm(8'hFF, 8'hAA);
    check("txCode quiet", txCode, 8'h55);
    check("rxSample quiet", rxSample, 8'h00);
    // quiet again with the law pin low, so the mu-law quiet code shows
    lawPin = 1'b0;
    pcm(8'hFF, 8'h7F);
    pcm(8'hFF, 8'h7F);
    check("txCode quiet mu", txCode, 8'h7F);
    check("rxSample quiet mu", rxSample, 8'h00);
    lawPin = 1'b1;
    wr(1'b0, 4'h3, 8'h00);
    pcm(8'hFF, 8'hAA);
    check("txCode live", txCode, 8'hAA);
    check("rxSample live", rxSample, 8'hFF);
    $display("test pcm done");
    // mid-run reset must bring every default back
    @(posedge clk);
    #1;
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    nrst = 1'b1;
    check("settings after reset", settings, 0);
    rdchk(1'b0, 4'h0, 8'h00);
    rdchk(1'b1, 4'h4, 8'h00);
    $display("test reset again done");
    check("line A misdriven", badOe, 0);
    tally_and_finish;
  end
endmodule
